// File: logic/qppc_top.sv
// Functional notes
// - chip reset low keeps ports off and all registers at power-up values.
// - chip reset high again starts normal operation.
// - chip reset low pulses under one microsecond are ignored.
// - alert pin pulls low when any unmasked event is pending.
// - writing bit 6 or 7 of the reset pushbutton register releases alert.
// - each alert event source is gated by its alert mask bit.
// - alert pin only changes between serial bus transactions.
// - an event during a transaction raises alert only after the stop.
// - answer only address 010 followed by the four address straps.
// - serial data split into sense input and open-drain drive output.
// - port shutdown pin low forces that port off.
// - shutdown pin low acts like the port reset pushbutton bit.
// - shutdown pin low glitches under one microsecond are ignored.
// - fault timer counts while port current is over threshold.
// - timer expiry turns port off and records overload or startup event.
// - power-good set while output monitor is below its threshold.
// - reset loads one of two register value sets picked by strap.
// - strap-preset bits stay writable over the serial bus.
// - live standalone strap level reads at pin state bit 0.
`timescale 1ns/10ps
`default_nettype none
module qppc_top
	import qppc_pkg::*;
#(
	parameter int FAULT_CYCLES = FAULT_CYCLES_DEF
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic chip_reset_n_in,
	input wire logic scl_in,
	input wire logic serial_data_sense_in,
	input wire logic standalone_strap_in,
	input wire logic [3:0] slave_addr_strap_in,
	input wire logic [3:0] port_off_n_in,
	input wire logic [3:0] current_over_threshold_in,
	input wire logic [3:0] port_low_drop_in,
	output logic serial_data_drive_out,
	output logic serial_data_drive_oe_out,
	output logic alert_out,
	output logic alert_oe_out,
	output logic [3:0] fet_drive_out,
	output logic [3:0] power_good_out
);
	localparam logic [FAULT_CNT_W-1:0] FAULT_MAX = FAULT_CNT_W'(FAULT_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchroniser
	qppc_pins_t pins_raw;
	qppc_pins_t sync1_r;
	qppc_pins_t s;
	qppc_pins_t prev_r;
	assign pins_raw = '{chip_reset_n: chip_reset_n_in, scl: scl_in, sda: serial_data_sense_in,
		standalone: standalone_strap_in, addr: slave_addr_strap_in, off_n: port_off_n_in,
		over: current_over_threshold_in, low_drop: port_low_drop_in};

	// two stages; only s and its delayed copy feed logic
	always_ff @(posedge clk_in) begin
		sync1_r <= pins_raw;
		s <= sync1_r;
		prev_r <= s;
	end

	////////////////////////////////////////////////////////////////////////////////
	// glitch filters on chip reset and shutdown pins
	logic [FILT_W-1:0] crst_cnt_r, crst_cnt_nxt;
	logic [FILT_W-1:0] off_cnt_r [NPORT];
	logic [FILT_W-1:0] off_cnt_nxt [NPORT];
	logic chip_low;
	logic rst_i;
	logic [3:0] off_act;

	// a low level must persist a full microsecond before it counts
	always_comb begin
		crst_cnt_nxt = crst_cnt_r;
		if (s.chip_reset_n) begin
			crst_cnt_nxt = '0;
		end else if (!chip_low) begin
			crst_cnt_nxt = crst_cnt_r + 1'b1;
		end
		for (int i = 0; i < NPORT; i++) begin
			off_cnt_nxt[i] = off_cnt_r[i];
			if (s.off_n[i]) begin
				off_cnt_nxt[i] = '0;
			end else if (!off_act[i]) begin
				off_cnt_nxt[i] = off_cnt_r[i] + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			crst_cnt_r <= '0;
			for (int i = 0; i < NPORT; i++) off_cnt_r[i] <= '0;
		end else begin
			crst_cnt_r <= crst_cnt_nxt;
			for (int i = 0; i < NPORT; i++) off_cnt_r[i] <= off_cnt_nxt[i];
		end
	end

	assign chip_low = (crst_cnt_r == FILT_MAX);
	assign rst_i = srst_in | chip_low;
	always_comb begin
		for (int i = 0; i < NPORT; i++) off_act[i] = (off_cnt_r[i] == FILT_MAX);
	end

	a_reset_filter: assert property (@(posedge clk_in) disable iff (srst_in)
		$rose(chip_low) |-> !$past(s.chip_reset_n, 10)) else $error("reset filter too short");
	a_reset_release: assert property (@(posedge clk_in) disable iff (srst_in)
		$fell(chip_low) |-> $past(s.chip_reset_n)) else $error("reset left without pin high");

	////////////////////////////////////////////////////////////////////////////////
	// serial slave
	qppc_state_t st_r, st_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [7:0] ptr_r, ptr_nxt;
	logic rw_r, rw_nxt;
	logic nack_r, nack_nxt;
	logic oe_r, oe_nxt;
	logic busy_r, busy_nxt;
	logic wr_en;
	logic [7:0] rd_data;
	logic scl_rise, scl_fall, bus_start, bus_stop;

	assign scl_rise = s.scl & ~prev_r.scl;
	assign scl_fall = ~s.scl & prev_r.scl;
	assign bus_start = s.scl & prev_r.scl & prev_r.sda & ~s.sda;
	assign bus_stop = s.scl & prev_r.scl & ~prev_r.sda & s.sda;

	// bits sampled on rising clock, data driven after falling clock
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		ptr_nxt = ptr_r;
		rw_nxt = rw_r;
		nack_nxt = nack_r;
		oe_nxt = oe_r;
		busy_nxt = busy_r;
		wr_en = 1'b0;
		if (bus_stop) begin
			st_nxt = ST_IDLE;
			oe_nxt = 1'b0;
			busy_nxt = 1'b0;
		end else if (bus_start) begin
			st_nxt = ST_ADDR;
			cnt_nxt = '0;
			oe_nxt = 1'b0;
			busy_nxt = 1'b1;
		end else if (scl_rise) begin
			unique case (st_r)
				ST_ADDR, ST_PTR, ST_WDAT: begin
					sh_nxt = {sh_r[6:0], s.sda};
					cnt_nxt = cnt_r + 1'b1;
				end
				ST_RDAT: cnt_nxt = cnt_r + 1'b1;
				ST_RACK: nack_nxt = s.sda;
				ST_IDLE, ST_AACK, ST_PACK, ST_WACK: begin
				end
			endcase
		end else if (scl_fall) begin
			unique case (st_r)
				ST_IDLE: begin
				end
				ST_ADDR: if (cnt_r == BIT_CNT_FULL) begin
					cnt_nxt = '0;
					if (sh_r[7:1] == {ADDR_PREFIX, s.addr}) begin
						st_nxt = ST_AACK;
						rw_nxt = sh_r[0];
						oe_nxt = 1'b1;
					end else begin
						st_nxt = ST_IDLE;
					end
				end
				ST_AACK: if (rw_r) begin
					st_nxt = ST_RDAT;
					sh_nxt = rd_data;
					oe_nxt = ~rd_data[7];
				end else begin
					st_nxt = ST_PTR;
					oe_nxt = 1'b0;
				end
				ST_PTR: if (cnt_r == BIT_CNT_FULL) begin
					ptr_nxt = sh_r;
					cnt_nxt = '0;
					st_nxt = ST_PACK;
					oe_nxt = 1'b1;
				end
				ST_PACK, ST_WACK: begin
					st_nxt = ST_WDAT;
					oe_nxt = 1'b0;
				end
				ST_WDAT: if (cnt_r == BIT_CNT_FULL) begin
					wr_en = 1'b1;
					ptr_nxt = ptr_r + 8'h01;
					cnt_nxt = '0;
					st_nxt = ST_WACK;
					oe_nxt = 1'b1;
				end
				ST_RDAT: if (cnt_r == BIT_CNT_FULL) begin
					ptr_nxt = ptr_r + 8'h01;
					cnt_nxt = '0;
					st_nxt = ST_RACK;
					oe_nxt = 1'b0;
				end else begin
					sh_nxt = {sh_r[6:0], 1'b0};
					oe_nxt = ~sh_r[6];
				end
				ST_RACK: if (nack_r) begin
					st_nxt = ST_IDLE;
				end else begin
					st_nxt = ST_RDAT;
					sh_nxt = rd_data;
					oe_nxt = ~rd_data[7];
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_i) begin
			st_r <= ST_IDLE;
			cnt_r <= '0;
			sh_r <= '0;
			ptr_r <= '0;
			rw_r <= 1'b0;
			nack_r <= 1'b0;
			oe_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			ptr_r <= ptr_nxt;
			rw_r <= rw_nxt;
			nack_r <= nack_nxt;
			oe_r <= oe_nxt;
			busy_r <= busy_nxt;
		end
	end

	// open drain: only ever pulls low
	assign serial_data_drive_out = 1'b0;
	assign serial_data_drive_oe_out = oe_r;

	a_addr_match: assert property (@(posedge clk_in) disable iff (rst_i)
		(st_r == ST_AACK && $past(st_r) == ST_ADDR) |-> $past(sh_r[7:1]) == {ADDR_PREFIX, s.addr})
		else $error("acknowledged foreign address");
	a_ack_drive: assert property (@(posedge clk_in) disable iff (rst_i)
		(st_r == ST_AACK || st_r == ST_PACK || st_r == ST_WACK) |-> serial_data_drive_oe_out)
		else $error("acknowledge not driven");

	////////////////////////////////////////////////////////////////////////////////
	// registers, port control and alert
	logic [7:0] mask_r, mask_nxt;
	logic [3:0] power_r, power_nxt;
	logic [3:0] ovl_evt_r, ovl_evt_nxt;
	logic [3:0] start_evt_r, start_evt_nxt;
	logic [3:0] startup_r, startup_nxt;
	logic [3:0] pgood_r, pgood_nxt;
	logic [7:0] pend_r, pend_nxt;
	logic alert_r, alert_nxt;
	logic [FAULT_CNT_W-1:0] tmr_r [NPORT];
	logic [FAULT_CNT_W-1:0] tmr_nxt [NPORT];
	logic [3:0] trip;
	logic [7:0] evt_set;
	logic pb_wr, pb_clr;

	assign pb_wr = wr_en && (ptr_r == REG_RESET_PUSHBUTTON);
	assign pb_clr = pb_wr && (sh_r[PB_CLR_LO] || sh_r[PB_CLR_HI]);

	// register read mux; pushbutton is write-only and reads zero
	always_comb begin
		unique case (ptr_r)
			REG_ALERT_MASK: rd_data = mask_r;
			REG_OVL_EVT: rd_data = {4'h0, ovl_evt_r};
			REG_START_EVT: rd_data = {4'h0, start_evt_r};
			REG_PIN_STATE: rd_data = {3'h0, s.addr, s.standalone};
			REG_PORT_POWER: rd_data = {4'h0, power_r};
			default: rd_data = 8'h00;
		endcase
	end

	// startup flag decides which timeout a trip records
	always_comb begin
		for (int i = 0; i < NPORT; i++) begin
			trip[i] = power_r[i] && s.over[i] && (tmr_r[i] == FAULT_MAX);
			tmr_nxt[i] = (power_r[i] && s.over[i] && !trip[i]) ? tmr_r[i] + 1'b1 : '0;
		end
		mask_nxt = (wr_en && ptr_r == REG_ALERT_MASK) ? sh_r : mask_r;
		power_nxt = (wr_en && ptr_r == REG_PORT_POWER) ? sh_r[3:0] : power_r;
		if (pb_wr) begin
			power_nxt = power_nxt & ~sh_r[3:0];
		end
		power_nxt = power_nxt & ~off_act & ~trip;
		pgood_nxt = s.low_drop;
		startup_nxt = (startup_r & ~pgood_r) | (power_nxt & ~power_r);
		ovl_evt_nxt = ovl_evt_r | (trip & ~startup_r);
		start_evt_nxt = start_evt_r | (trip & startup_r);
		evt_set = 8'h00;
		evt_set[MASK_START] = |(trip & startup_r);
		evt_set[MASK_OVL] = |(trip & ~startup_r);
		evt_set[MASK_PGOOD] = (pgood_nxt != pgood_r);
		evt_set[MASK_PWR_EN] = (power_nxt != power_r);
		evt_set = evt_set & mask_r;
		// a new event in the clearing cycle survives the clear
		pend_nxt = (pend_r & ~{8{pb_clr}}) | evt_set;
		// alert frozen while a transaction is in flight
		alert_nxt = busy_r ? alert_r : (|pend_r);
	end

	always_ff @(posedge clk_in) begin
		if (rst_i) begin
			mask_r <= s.standalone ? MASK_RST_HI : MASK_RST_LO;
			power_r <= s.standalone ? POWER_RST_HI : POWER_RST_LO;
			ovl_evt_r <= '0;
			start_evt_r <= '0;
			startup_r <= s.standalone ? POWER_RST_HI : POWER_RST_LO;
			pgood_r <= '0;
			pend_r <= '0;
			alert_r <= 1'b0;
			for (int i = 0; i < NPORT; i++) tmr_r[i] <= '0;
		end else begin
			mask_r <= mask_nxt;
			power_r <= power_nxt;
			ovl_evt_r <= ovl_evt_nxt;
			start_evt_r <= start_evt_nxt;
			startup_r <= startup_nxt;
			pgood_r <= pgood_nxt;
			pend_r <= pend_nxt;
			alert_r <= alert_nxt;
			for (int i = 0; i < NPORT; i++) tmr_r[i] <= tmr_nxt[i];
		end
	end

	// gate drive off in reset so ports never glitch on
	assign fet_drive_out = rst_i ? 4'h0 : power_r;
	assign power_good_out = pgood_r;
	assign alert_out = 1'b0;
	assign alert_oe_out = alert_r;

	a_reset_ports: assert property (@(posedge clk_in)
		rst_i |-> fet_drive_out == 4'h0) else $error("port on during reset");
	a_port_off_pin: assert property (@(posedge clk_in) disable iff (rst_i)
		off_act != 4'h0 |=> (power_r & $past(off_act)) == 4'h0) else $error("shutdown ignored");
	a_fault_trip: assert property (@(posedge clk_in) disable iff (rst_i)
		trip[0] |=> !power_r[0] && (ovl_evt_r[0] || start_evt_r[0])) else $error("trip lost");
	a_timer_count: assert property (@(posedge clk_in) disable iff (rst_i)
		(power_r[0] && s.over[0] && !trip[0]) |=> tmr_r[0] == $past(tmr_r[0]) + 1'b1)
		else $error("fault timer stalled");
	a_mask_gate: assert property (@(posedge clk_in) disable iff (rst_i)
		((pend_r & ~$past(pend_r)) & ~$past(mask_r)) == 8'h00) else $error("masked event pending");
	a_alert_clear: assert property (@(posedge clk_in) disable iff (rst_i)
		(pb_clr && evt_set == 8'h00) |=> pend_r == 8'h00) else $error("alert not cleared");
	a_alert_busy: assert property (@(posedge clk_in) disable iff (rst_i)
		busy_r |=> $stable(alert_oe_out)) else $error("alert moved mid transaction");
	a_alert_raise: assert property (@(posedge clk_in) disable iff (rst_i)
		(!busy_r && pend_r != 8'h00) |=> alert_oe_out) else $error("pending event not signalled");
	a_alert_stop: assert property (@(posedge clk_in) disable iff (rst_i)
		($fell(busy_r) && pend_r != 8'h00) |=> alert_oe_out) else $error("alert late after stop");
	a_strap_reset: assert property (@(posedge clk_in)
		$fell(rst_i) |-> mask_r == ($past(s.standalone) ? MASK_RST_HI : MASK_RST_LO))
		else $error("wrong strap reset set");
endmodule
`default_nettype wire

// File: logic/qppc_pkg.sv
`default_nettype none
package qppc_pkg;
	// clock and pin filter timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int FILTER_TIME_NS = 1000;
	localparam int FILT_CYCLES = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT_W = 4;
	localparam logic [FILT_W-1:0] FILT_MAX = FILT_W'(FILT_CYCLES);
	// fault timer length, plain default, and port count
	localparam int FAULT_TIME_US = 60;
	localparam int FAULT_CYCLES_DEF = FAULT_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int FAULT_CNT_W = 20;
	localparam int NPORT = 4;
	// register offsets
	localparam logic [7:0] REG_ALERT_MASK = 8'h01;
	localparam logic [7:0] REG_OVL_EVT = 8'h06;
	localparam logic [7:0] REG_START_EVT = 8'h08;
	localparam logic [7:0] REG_PIN_STATE = 8'h11;
	localparam logic [7:0] REG_PORT_POWER = 8'h12;
	localparam logic [7:0] REG_RESET_PUSHBUTTON = 8'h1A;
	// serial address prefix
	localparam logic [2:0] ADDR_PREFIX = 3'h2;
	// field positions
	localparam int PB_CLR_LO = 6;
	localparam int PB_CLR_HI = 7;
	localparam int MASK_START = 6;
	localparam int MASK_OVL = 5;
	localparam int MASK_PGOOD = 1;
	localparam int MASK_PWR_EN = 0;
	localparam int PIN_STRAP_BIT = 0;
	// strap-selected reset values, then full serial bit count
	localparam logic [7:0] MASK_RST_LO = 8'h80;
	localparam logic [7:0] MASK_RST_HI = 8'hE4;
	localparam logic [3:0] POWER_RST_LO = 4'h0;
	localparam logic [3:0] POWER_RST_HI = 4'hF;
	localparam logic [3:0] BIT_CNT_FULL = 4'h8;
	// serial slave states
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_AACK = 9'h004,
		ST_PTR = 9'h008,
		ST_PACK = 9'h010,
		ST_WDAT = 9'h020,
		ST_WACK = 9'h040,
		ST_RDAT = 9'h080,
		ST_RACK = 9'h100
	} qppc_state_t;
	// all asynchronous pins, synchronised together
	typedef struct packed {
		logic chip_reset_n;
		logic scl;
		logic sda;
		logic standalone;
		logic [3:0] addr;
		logic [3:0] off_n;
		logic [3:0] over;
		logic [3:0] low_drop;
	} qppc_pins_t;
endpackage
`default_nettype wire

// File: tb/qppc_host.sv
`timescale 1ns/10ps
`default_nettype none
// bit-banged two-wire master; scl only moves inside frames
module qppc_host (
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_oe_out
);
	// set between a start and its stop, so idle scl never pulses
	logic in_frame = 1'b0;
	// bus idles released: scl driven high, pull-up holds sda high
	initial begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	////////////////////////////////////////////////////////////////
	// a=0,b=1 gives a start, a=1,b=0 a stop; 800 ns per scl period
	task automatic cond(input logic a, input logic b);
		// a start from an idle bus needs no low phase on scl
		if (in_frame || a) begin
			scl_out <= 1'b0;
			tick(2);
			sda_oe_out <= a;
			tick(2);
			scl_out <= 1'b1;
			tick(4);
		end
		sda_oe_out <= b;
		tick(4);
		in_frame = b;
	endtask
	// data moves mid-low, sampled late in the high phase
	task automatic bitx(input logic b, output logic r);
		scl_out <= 1'b0;
		tick(2);
		sda_oe_out <= ~b;
		tick(2);
		scl_out <= 1'b1;
		tick(3);
		r = sda_in;
		tick(1);
	endtask
	// msb first, ninth bit carries ack or nack
	task automatic byte_io(input logic [7:0] d, input logic last,
		output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
			q[i] = r;
		end
		bitx(last, r);
		ack = ~r;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic wr_reg(input logic [6:0] dev, input logic [7:0] off,
		input logic [7:0] dat, output logic ok);
		logic [7:0] q;
		logic a0, a1, a2;
		cond(1'b0, 1'b1);
		byte_io({dev, 1'b0}, 1'b1, q, a0);
		byte_io(off, 1'b1, q, a1);
		byte_io(dat, 1'b1, q, a2);
		cond(1'b1, 1'b0);
		ok = a0 & a1 & a2;
	endtask
	// pointer write, repeated start, one byte read ended by nack
	task automatic rd_reg(input logic [6:0] dev, input logic [7:0] off,
		output logic [7:0] dat, output logic ok);
		logic [7:0] q;
		logic a0, a1, a2, a3;
		cond(1'b0, 1'b1);
		byte_io({dev, 1'b0}, 1'b1, q, a0);
		byte_io(off, 1'b1, q, a1);
		cond(1'b0, 1'b1);
		byte_io({dev, 1'b1}, 1'b1, q, a2);
		byte_io(8'hFF, 1'b1, dat, a3);
		cond(1'b1, 1'b0);
		ok = a0 & a1 & a2;
	endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench;
	import qppc_pkg::*;
	localparam int FLT = 20;
	localparam logic [3:0] STRAP = 4'hA;
	localparam logic [6:0] DEV = {ADDR_PREFIX, STRAP};
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic chip_reset_n_in = 1'b1;
	logic standalone_strap_in = 1'b0;
	logic [3:0] slave_addr_strap_in = STRAP;
	logic [3:0] port_off_n_in = 4'hF;
	logic [3:0] over_in = 4'h0;
	logic [3:0] low_drop_in = 4'h0;
	logic scl, host_oe, sda_wire, drive, drive_oe, alert, alert_oe;
	logic [3:0] fet_drive_out, power_good_out;
	int err_count = 0;
	int checks_done = 0;
	// pulled-up data wire, low if either side pulls
	assign sda_wire = ~(host_oe | drive_oe);
	always #50 clk_in = ~clk_in;
	qppc_host qppc_host_i (.clk_in(clk_in), .sda_in(sda_wire), .scl_out(scl),
		.sda_oe_out(host_oe));
	qppc_top #(.FAULT_CYCLES(FLT)) qppc_top_i (.clk_in(clk_in), .srst_in(srst_in),
		.chip_reset_n_in(chip_reset_n_in), .scl_in(scl), .serial_data_sense_in(sda_wire),
		.standalone_strap_in(standalone_strap_in), .slave_addr_strap_in(slave_addr_strap_in),
		.port_off_n_in(port_off_n_in), .current_over_threshold_in(over_in),
		.port_low_drop_in(low_drop_in), .serial_data_drive_out(drive),
		.serial_data_drive_oe_out(drive_oe), .alert_out(alert), .alert_oe_out(alert_oe),
		.fet_drive_out(fet_drive_out), .power_good_out(power_good_out));
	////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic wr(input logic [7:0] off, input logic [7:0] d);
		logic ok;
		qppc_host_i.wr_reg(DEV, off, d, ok);
		`CHK("write_ack", 1'b1, ok)
	endtask
	task automatic rd_chk(input logic [7:0] off, input logic [7:0] e);
		logic [7:0] d;
		logic ok;
		qppc_host_i.rd_reg(DEV, off, d, ok);
		`CHK("read_ack", 1'b1, ok)
		`CHK("read_data", e, d)
	endtask
	// bounded wait so a stuck gate shows as a mismatch, not a hang
	task automatic wait_fet(input int p, input logic v);
		for (int i = 0; i < 60 && fet_drive_out[p] !== v; i++) cyc(1);
		`CHK("fet_bit", v, fet_drive_out[p])
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		`CHK("fet_drive", 4'h0, fet_drive_out)
		`CHK("sda_drive", 1'b0, drive)
		`CHK("alert_pin", 1'b0, alert)
		rd_chk(REG_ALERT_MASK, MASK_RST_LO);
		rd_chk(REG_PORT_POWER, {4'h0, POWER_RST_LO});
		rd_chk(REG_PIN_STATE, {3'h0, STRAP, 1'b0});
		$display("t_reset done");
	endtask
	// wrong straps or prefix must get no ack and change nothing
	task automatic t_addr();
		logic ok;
		qppc_host_i.wr_reg({ADDR_PREFIX, 4'h5}, REG_ALERT_MASK, 8'h00, ok);
		`CHK("wrong_strap_ack", 1'b0, ok)
		qppc_host_i.wr_reg({3'h3, STRAP}, REG_ALERT_MASK, 8'h00, ok);
		`CHK("wrong_prefix_ack", 1'b0, ok)
		rd_chk(REG_ALERT_MASK, MASK_RST_LO);
		rd_chk(8'h1F, 8'h00);
		rd_chk(REG_RESET_PUSHBUTTON, 8'h00);
		$display("t_addr done");
	endtask
	task automatic t_power();
		wr(REG_PORT_POWER, 8'h0F);
		wait_fet(0, 1'b1);
		port_off_n_in[0] <= 1'b0;
		cyc(FILT_CYCLES - 2);
		port_off_n_in[0] <= 1'b1;
		cyc(8);
		`CHK("fet_glitch", 4'hF, fet_drive_out)
		port_off_n_in[0] <= 1'b0;
		wait_fet(0, 1'b0);
		port_off_n_in[0] <= 1'b1;
		wr(REG_RESET_PUSHBUTTON, 8'h08);
		wait_fet(3, 1'b0);
		rd_chk(REG_PORT_POWER, 8'h06);
		low_drop_in <= 4'h2;
		cyc(5);
		`CHK("power_good", 4'h2, power_good_out)
		$display("t_power done");
	endtask
	// port 2 trips in startup, port 1 after power good: overload
	task automatic t_fault();
		over_in[2] <= 1'b1;
		cyc(FLT / 2);
		over_in[2] <= 1'b0;
		cyc(FLT);
		over_in[2] <= 1'b1;
		cyc(FLT - 2);
		`CHK("fet_early", 4'h6, fet_drive_out)
		wait_fet(2, 1'b0);
		over_in[1] <= 1'b1;
		wait_fet(1, 1'b0);
		over_in <= 4'h0;
		rd_chk(REG_START_EVT, 8'h04);
		rd_chk(REG_OVL_EVT, 8'h02);
		$display("t_fault done");
	endtask
	task automatic t_alert();
		logic ok;
		`CHK("alert_masked", 1'b0, alert_oe)
		// masked trips never set a pending bit, so unmasking alone stays quiet
		wr(REG_ALERT_MASK, 8'h60);
		cyc(3);
		`CHK("alert_unmask", 1'b0, alert_oe)
		// port 0 is still in startup, so its trip is a startup event
		wr(REG_PORT_POWER, 8'h01);
		wait_fet(0, 1'b1);
		over_in[0] <= 1'b1;
		wait_fet(0, 1'b0);
		over_in <= 4'h0;
		cyc(3);
		`CHK("alert_set", 1'b1, alert_oe)
		wr(REG_RESET_PUSHBUTTON, 8'h40);
		cyc(3);
		`CHK("alert_clr6", 1'b0, alert_oe)
		wr(REG_PORT_POWER, 8'h01);
		wait_fet(0, 1'b1);
		// trip lands while a long write is still on the bus
		fork
			qppc_host_i.wr_reg(DEV, REG_ALERT_MASK, 8'h60, ok);
			begin
				over_in[0] <= 1'b1;
				wait_fet(0, 1'b0);
				cyc(4);
				`CHK("alert_mid", 1'b0, alert_oe)
			end
		join
		`CHK("mid_ack", 1'b1, ok)
		over_in <= 4'h0;
		cyc(3);
		`CHK("alert_stop", 1'b1, alert_oe)
		wr(REG_RESET_PUSHBUTTON, 8'h80);
		cyc(3);
		`CHK("alert_clr7", 1'b0, alert_oe)
		$display("t_alert done");
	endtask
	task automatic t_chip();
		wr(REG_PORT_POWER, 8'h0F);
		wait_fet(3, 1'b1);
		chip_reset_n_in <= 1'b0;
		cyc(FILT_CYCLES - 2);
		chip_reset_n_in <= 1'b1;
		cyc(8);
		`CHK("fet_chip_glitch", 4'hF, fet_drive_out)
		standalone_strap_in <= 1'b1;
		chip_reset_n_in <= 1'b0;
		cyc(FILT_CYCLES + 6);
		`CHK("fet_in_reset", 4'h0, fet_drive_out)
		chip_reset_n_in <= 1'b1;
		cyc(8);
		`CHK("fet_strap_high", POWER_RST_HI, fet_drive_out)
		rd_chk(REG_ALERT_MASK, MASK_RST_HI);
		rd_chk(REG_PIN_STATE, {3'h0, STRAP, 1'b1});
		rd_chk(REG_START_EVT, 8'h00);
		wr(REG_ALERT_MASK, 8'h00);
		rd_chk(REG_ALERT_MASK, 8'h00);
		$display("t_chip done");
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence after a six-cycle synchronous reset
	initial begin
		cyc(6);
		srst_in <= 1'b0;
		cyc(10);
		t_reset();
		t_addr();
		t_power();
		t_fault();
		t_alert();
		t_chip();
		tally_and_finish();
	end
	// watchdog sized well above the roughly 7k cycles the tests need
	initial begin
		cyc(60000);
		err_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
